// ---- src/cls_io_regs.sv ----
/*
  Card unit attachment: load-I/O and sense-I/O instruction handling, the loaded count,
  head select and buffer address registers, and the start-I/O length check.
  Assumes the processing unit presents one instruction per strobe with both storage
  bytes already fetched, and reads the sense bytes one cycle after the strobe.
*/
`timescale 1ns/1ps
module cls_io_regs (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_qbyte,
  input wire logic [7:0] instr_byte_op,
  input wire logic [7:0] instr_byte_op_m1,
  input wire logic cpu_level7_active,
  input wire logic cpu_level7_enabled,
  input wire logic print_installed,
  input wire logic sio_valid,
  input wire logic [1:0] sio_kind,
  output logic load_done,
  output logic sense_valid,
  output logic [7:0] sense_byte_op,
  output logic [7:0] sense_byte_op_m1,
  output logic processor_check,
  output logic program_check,
  output logic sio_accept,
  output logic sio_abort,
  output logic [7:0] sio_length,
  output logic [15:0] sio_address,
  output logic [5:0] sio_heads,
  output logic diag_mode,
  output logic aborted_op_flag
);

  // ****************************************
  // Decode
  // ****************************************
  logic addressed;
  logic is_load;
  logic is_sense;
  logic [2:0] func;
  logic [15:0] field;

  assign addressed = (instr_qbyte[cls_pkg::QB_DEV_LSB +: 4] == cls_pkg::DEVICE_ADDR);
  assign func = instr_qbyte[cls_pkg::QB_FUNC_LSB +: 3];
  // Addressing modes differ only in how the CPU fetched the field
  assign is_load = instr_valid && addressed &&
                   ((instr_opcode == cls_pkg::OP_LOAD_DIRECT) ||
                    (instr_opcode == cls_pkg::OP_LOAD_XR1) ||
                    (instr_opcode == cls_pkg::OP_LOAD_XR2));
  assign is_sense = instr_valid && addressed &&
                    ((instr_opcode == cls_pkg::OP_SENSE_DIRECT) ||
                     (instr_opcode == cls_pkg::OP_SENSE_XR1) ||
                     (instr_opcode == cls_pkg::OP_SENSE_XR2));
  // Operand byte is the low-order end of the two-byte field
  assign field = {instr_byte_op_m1, instr_byte_op};

  // ****************************************
  // Loaded registers
  // ****************************************
  logic [7:0] read_length_count;
  logic [7:0] punch_length_count;
  logic [7:0] print_head_select;
  logic [7:0] print_length_count;
  logic [15:0] print_buffer_address;
  logic [15:0] read_buffer_address;
  logic [15:0] punch_buffer_address;
  logic [7:0] next_read_length_count;
  logic [7:0] next_punch_length_count;
  logic [7:0] next_print_head_select;
  logic [7:0] next_print_length_count;
  logic [15:0] next_print_buffer_address;
  logic [15:0] next_read_buffer_address;
  logic [15:0] next_punch_buffer_address;
  logic next_diag_mode;
  logic load_abort;
  logic load_bad_func;

  // Each register changes only on its own function code; otherwise it holds
  always_comb begin
    next_read_length_count = read_length_count;
    next_punch_length_count = punch_length_count;
    next_print_head_select = print_head_select;
    next_print_length_count = print_length_count;
    next_print_buffer_address = print_buffer_address;
    next_read_buffer_address = read_buffer_address;
    next_punch_buffer_address = punch_buffer_address;
    next_diag_mode = diag_mode;
    load_abort = 1'b0;
    load_bad_func = 1'b0;
    if (is_load) begin
      case (func)
        cls_pkg::FN_READ_COUNT: begin
          next_read_length_count = instr_byte_op;
        end
        cls_pkg::FN_DIAG: begin
          next_diag_mode = instr_byte_op[cls_pkg::DIAG_MODE_BIT];
        end
        cls_pkg::FN_PUNCH_COUNT: begin
          next_punch_length_count = instr_byte_op_m1;
        end
        cls_pkg::FN_PRINT_CTRL: begin
          // Head select and count both left unloaded, and the aborted flag set, when no head is chosen
          if (instr_byte_op[5:0] == 6'h00) begin
            load_abort = 1'b1;
          end else begin
            next_print_head_select = instr_byte_op;
            next_print_length_count = instr_byte_op_m1;
          end
        end
        cls_pkg::FN_PRINT_ADDR: begin
          next_print_buffer_address = field;
        end
        cls_pkg::FN_READ_ADDR: begin
          next_read_buffer_address = field;
        end
        cls_pkg::FN_PUNCH_ADDR: begin
          next_punch_buffer_address = field;
        end
        default: begin
          load_bad_func = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      read_length_count <= cls_pkg::COUNT_RESET;
      punch_length_count <= cls_pkg::COUNT_RESET;
      print_head_select <= cls_pkg::HEADS_RESET;
      print_length_count <= cls_pkg::COUNT_RESET;
      print_buffer_address <= cls_pkg::ADDR_RESET;
      read_buffer_address <= cls_pkg::ADDR_RESET;
      punch_buffer_address <= cls_pkg::ADDR_RESET;
      diag_mode <= 1'b0;
    end else begin
      read_length_count <= next_read_length_count;
      punch_length_count <= next_punch_length_count;
      print_head_select <= next_print_head_select;
      print_length_count <= next_print_length_count;
      print_buffer_address <= next_print_buffer_address;
      read_buffer_address <= next_read_buffer_address;
      punch_buffer_address <= next_punch_buffer_address;
      diag_mode <= next_diag_mode;
    end
  end

  // ****************************************
  // Start-I/O check
  // ****************************************
  cls_pkg::cls_kind_t kind;
  logic [7:0] chk_length;
  logic chk_abort;

  assign kind = cls_pkg::cls_kind_t'(sio_kind);

  cls_sio_check u_check (
    .kind(kind),
    .read_count(read_length_count),
    .punch_count(punch_length_count),
    .print_count(print_length_count),
    .heads(print_head_select),
    .print_installed(print_installed),
    .length(chk_length),
    .abort(chk_abort)
  );

  // ****************************************
  // Answer sequencer and outputs
  // ****************************************
  cls_pkg::cls_state_t state;
  cls_pkg::cls_state_t next_state;
  logic next_load_done;
  logic next_sense_valid;
  logic [7:0] next_sense_byte_op;
  logic [7:0] next_sense_byte_op_m1;
  logic next_processor_check;
  logic next_program_check;
  logic next_sio_accept;
  logic next_sio_abort;
  logic [7:0] next_sio_length;
  logic [15:0] next_sio_address;
  logic [5:0] next_sio_heads;
  logic next_aborted_flag;
  logic abort_event;
  logic flag_clear;

  // Unknown kind codes are aborted by the checker as well
  assign abort_event = load_abort || (sio_valid && chk_abort);
  assign flag_clear = is_sense && (func == cls_pkg::FN_READ_COUNT);

  always_comb begin
    next_state = cls_pkg::CLS_IDLE;
    next_load_done = is_load;
    next_sense_valid = is_sense;
    next_sense_byte_op = sense_byte_op;
    next_sense_byte_op_m1 = sense_byte_op_m1;
    // Check goes to processor when level 7 is active but not enabled, to program when enabled, else nowhere
    next_processor_check = load_bad_func && cpu_level7_active && !cpu_level7_enabled;
    next_program_check = load_bad_func && cpu_level7_enabled;
    next_sio_accept = sio_valid && !chk_abort;
    next_sio_abort = sio_valid && chk_abort;
    next_sio_length = sio_length;
    next_sio_address = sio_address;
    next_sio_heads = sio_heads;
    // Set beats a sensing clear in the same cycle
    if (abort_event) begin
      next_aborted_flag = 1'b1;
    end else if (flag_clear) begin
      next_aborted_flag = 1'b0;
    end else begin
      next_aborted_flag = aborted_op_flag;
    end
    if (is_load || is_sense || sio_valid) begin
      next_state = cls_pkg::CLS_ANSWER;
    end
    if (is_sense) begin
      case (func)
        cls_pkg::FN_READ_COUNT: begin
          next_sense_byte_op = 8'h00;
          next_sense_byte_op[cls_pkg::SNS_ABORTED_BIT] = aborted_op_flag;
          next_sense_byte_op[cls_pkg::SNS_DIAG_BIT] = diag_mode;
          next_sense_byte_op[cls_pkg::SNS_PRINT_OPT_BIT] = print_installed;
          next_sense_byte_op_m1 = print_head_select;
        end
        cls_pkg::FN_PRINT_ADDR: begin
          {next_sense_byte_op_m1, next_sense_byte_op} = print_buffer_address;
        end
        cls_pkg::FN_READ_ADDR: begin
          {next_sense_byte_op_m1, next_sense_byte_op} = read_buffer_address;
        end
        cls_pkg::FN_PUNCH_ADDR: begin
          {next_sense_byte_op_m1, next_sense_byte_op} = punch_buffer_address;
        end
        default: begin
          next_sense_byte_op = read_length_count;
          next_sense_byte_op_m1 = punch_length_count;
        end
      endcase
    end
    if (sio_valid && !chk_abort) begin
      next_sio_length = chk_length;
      next_sio_heads = 6'h00;
      case (kind)
        cls_pkg::CLS_KIND_READ: next_sio_address = read_buffer_address;
        cls_pkg::CLS_KIND_PUNCH: next_sio_address = punch_buffer_address;
        cls_pkg::CLS_KIND_PRINT: begin
          next_sio_address = print_buffer_address;
          next_sio_heads = print_head_select[5:0];
        end
        default: next_sio_address = sio_address;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= cls_pkg::CLS_IDLE;
      load_done <= 1'b0;
      sense_valid <= 1'b0;
      sense_byte_op <= 8'h00;
      sense_byte_op_m1 <= 8'h00;
      processor_check <= 1'b0;
      program_check <= 1'b0;
      sio_accept <= 1'b0;
      sio_abort <= 1'b0;
      sio_length <= cls_pkg::COUNT_RESET;
      sio_address <= cls_pkg::ADDR_RESET;
      sio_heads <= 6'h00;
      aborted_op_flag <= 1'b0;
    end else begin
      state <= next_state;
      load_done <= next_load_done;
      sense_valid <= next_sense_valid;
      sense_byte_op <= next_sense_byte_op;
      sense_byte_op_m1 <= next_sense_byte_op_m1;
      processor_check <= next_processor_check;
      program_check <= next_program_check;
      sio_accept <= next_sio_accept;
      sio_abort <= next_sio_abort;
      sio_length <= next_sio_length;
      sio_address <= next_sio_address;
      sio_heads <= next_sio_heads;
      aborted_op_flag <= next_aborted_flag;
    end
  end

endmodule : cls_io_regs

// ---- src/cls_pkg.sv ----
/*
  Package for the card unit load/sense I/O attachment: instruction codes, function codes,
  limits, sense bit positions and state encoding.
  Assumes a single synchronous clock domain, used by cls_io_regs and cls_sio_check.
*/
package cls_pkg;

  // ****************************************
  // Instruction decode
  // ****************************************
  localparam logic [3:0] DEVICE_ADDR = 4'hf;
  localparam logic [7:0] OP_LOAD_DIRECT = 8'h31;
  localparam logic [7:0] OP_LOAD_XR1 = 8'h71;
  localparam logic [7:0] OP_LOAD_XR2 = 8'hb1;
  localparam logic [7:0] OP_SENSE_DIRECT = 8'h30;
  localparam logic [7:0] OP_SENSE_XR1 = 8'h70;
  localparam logic [7:0] OP_SENSE_XR2 = 8'hb0;

  // Q-byte fields: device address, modifier bit, function code
  localparam int QB_DEV_LSB = 4;
  localparam int QB_FUNC_LSB = 0;

  // ****************************************
  // Function codes
  // ****************************************
  localparam logic [2:0] FN_READ_COUNT = 3'h0;
  localparam logic [2:0] FN_DIAG = 3'h1;
  localparam logic [2:0] FN_PUNCH_COUNT = 3'h2;
  localparam logic [2:0] FN_PRINT_CTRL = 3'h3;
  localparam logic [2:0] FN_PRINT_ADDR = 3'h4;
  localparam logic [2:0] FN_READ_ADDR = 3'h5;
  localparam logic [2:0] FN_PUNCH_ADDR = 3'h6;
  localparam logic [2:0] FN_INVALID = 3'h7;

  // ****************************************
  // Limits, fields and reset values
  // ****************************************
  localparam logic [7:0] PRINT_COUNT_MAX = 8'h40;
  localparam logic [7:0] CARD_COUNT_MAX = 8'h50;
  localparam int HEAD_COUNT = 6;
  localparam int DIAG_MODE_BIT = 0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] HEADS_RESET = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // Sense byte 1 bit positions
  localparam int SNS_ABORTED_BIT = 0;
  localparam int SNS_DIAG_BIT = 1;
  localparam int SNS_PRINT_OPT_BIT = 2;

  // Start kinds
  typedef enum logic [1:0] {
    CLS_KIND_READ = 2'h0,
    CLS_KIND_PUNCH = 2'h1,
    CLS_KIND_PRINT = 2'h2
  } cls_kind_t;

  // Answer sequencer, Gray along idle -> answer
  typedef enum logic [1:0] {
    CLS_IDLE = 2'h0,
    CLS_ANSWER = 2'h1
  } cls_state_t;

endpackage : cls_pkg

// ---- src/cls_sio_check.sv ----
/*
  Start-I/O check: clamps the length count of the chosen operation and decides abort.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
module cls_sio_check (
  input wire cls_pkg::cls_kind_t kind,
  input wire logic [7:0] read_count,
  input wire logic [7:0] punch_count,
  input wire logic [7:0] print_count,
  input wire logic [7:0] heads,
  input wire logic print_installed,
  output logic [7:0] length,
  output logic abort
);

  // ****************************************
  // Clamp helper
  // ****************************************
  function automatic logic [7:0] clamp(input logic [7:0] cnt, input logic [7:0] lim);
    clamp = (cnt > lim) ? lim : cnt;
  endfunction : clamp

  // ****************************************
  // Count choice and abort decision
  // ****************************************
  always_comb begin
    length = 8'h00;
    abort = 1'b0;
    case (kind)
      cls_pkg::CLS_KIND_READ: begin
        length = clamp(read_count, cls_pkg::CARD_COUNT_MAX);
        abort = (read_count == 8'h00);
      end
      cls_pkg::CLS_KIND_PUNCH: begin
        length = clamp(punch_count, cls_pkg::CARD_COUNT_MAX);
        abort = (punch_count == 8'h00);
      end
      cls_pkg::CLS_KIND_PRINT: begin
        length = clamp(print_count, cls_pkg::PRINT_COUNT_MAX);
        // Missing option runs anyway, so no zero checks apply
        abort = print_installed &&
                ((print_count == 8'h00) || (heads[5:0] == 6'h00));
      end
      default: begin
        length = 8'h00;
        abort = 1'b1;
      end
    endcase
  end

endmodule : cls_sio_check

// ---- dv/cls_io_regs_props.sv ----
/* Checker for cls_io_regs: answer timing of loads, senses and starts.
   Assumes one clock domain with synchronous active-high reset; bound below. */
`timescale 1ns/1ps
module cls_io_regs_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_qbyte,
  input wire logic [7:0] instr_byte_op,
  input wire logic [7:0] instr_byte_op_m1,
  input wire logic cpu_level7_active,
  input wire logic cpu_level7_enabled,
  input wire logic print_installed,
  input wire logic sio_valid,
  input wire logic [1:0] sio_kind,
  input wire logic load_done,
  input wire logic sense_valid,
  input wire logic [7:0] sense_byte_op,
  input wire logic [7:0] sense_byte_op_m1,
  input wire logic processor_check,
  input wire logic program_check,
  input wire logic sio_accept,
  input wire logic sio_abort,
  input wire logic [7:0] sio_length,
  input wire logic [15:0] sio_address,
  input wire logic [5:0] sio_heads,
  input wire logic diag_mode,
  input wire logic aborted_op_flag
);
  // ****************************************
  // Decode helpers
  // ****************************************
  logic addr_ok;
  logic is_load;
  logic is_sense;
  logic bad_fn;
  assign addr_ok = instr_valid && instr_qbyte[7:4] == 4'hf;
  assign is_load = addr_ok && (instr_opcode == 8'h31 || instr_opcode == 8'h71 ||
                               instr_opcode == 8'hb1);
  assign is_sense = addr_ok && (instr_opcode == 8'h30 || instr_opcode == 8'h70 ||
                                instr_opcode == 8'hb0);
  assign bad_fn = is_load && instr_qbyte[2:0] == 3'h7;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff sys_rst;
  property p_load; is_load |=> load_done; endproperty
  a_load: assert property (p_load) else $error("load not answered");
  property p_refuse;
    instr_valid && instr_qbyte[7:4] != 4'hf |=> !load_done && !sense_valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("foreign device answered");
  property p_sense; is_sense |=> sense_valid; endproperty
  a_sense: assert property (p_sense) else $error("sense not answered");
  property p_proc;
    bad_fn && cpu_level7_active && !cpu_level7_enabled |=> processor_check && !program_check;
  endproperty
  a_proc: assert property (p_proc) else $error("processor check missing");
  property p_prog; bad_fn && cpu_level7_enabled |=> program_check; endproperty
  a_prog: assert property (p_prog) else $error("program check missing");
  property p_answer; sio_valid |=> sio_accept != sio_abort; endproperty
  a_answer: assert property (p_answer) else $error("start answer wrong");
  property p_noopt; sio_valid && sio_kind == 2'h2 && !print_installed |=> sio_accept; endproperty
  a_noopt: assert property (p_noopt) else $error("print start refused");
  property p_clamp; sio_accept |-> sio_length <= (sio_heads != 6'h0 ? 8'h40 : 8'h50); endproperty
  a_clamp: assert property (p_clamp) else $error("length above maximum");
  property p_flag; sio_abort |-> ##[0:1] aborted_op_flag; endproperty
  a_flag: assert property (p_flag) else $error("abort flag not set");
  property p_hold; !sio_accept |-> $stable(sio_address) && $stable(sio_length); endproperty
  a_hold: assert property (p_hold) else $error("start values moved");
  c_load: cover property (load_done);
  c_abort: cover property (sio_abort);
  c_sense: cover property (sense_valid && sense_byte_op[0]);
endmodule : cls_io_regs_chk
bind cls_io_regs cls_io_regs_chk u_chk (.*);

// ---- dv/cls_cpu_model.sv ----
/* Processing unit stand-in: small storage, issues instructions and starts.
   Assumes the attachment samples on the rising edge; drives on the falling edge. */
`timescale 1ns/1ps
module cls_cpu_model (
  input wire logic sys_clk,
  output logic instr_valid,
  output logic [7:0] instr_opcode,
  output logic [7:0] instr_qbyte,
  output logic [7:0] instr_byte_op,
  output logic [7:0] instr_byte_op_m1,
  output logic sio_valid,
  output logic [1:0] sio_kind
);
  logic [7:0] mem [0:255];
  initial begin
    instr_valid = 1'b0;
    instr_opcode = 8'h00;
    instr_qbyte = 8'h00;
    instr_byte_op = 8'h00;
    instr_byte_op_m1 = 8'h00;
    sio_valid = 1'b0;
    sio_kind = 2'h0;
  end
  // One instruction; byte lines scrambled once released so stale data never matches
  task automatic issue(input logic [7:0] op, input logic [3:0] dev, input logic [2:0] fn,
                       input logic [7:0] adr);
    @(negedge sys_clk);
    instr_valid = 1'b1;
    instr_opcode = op;
    instr_qbyte = {dev, 1'b0, fn};
    instr_byte_op = mem[adr];
    instr_byte_op_m1 = mem[adr - 8'h01];
    @(negedge sys_clk);
    instr_valid = 1'b0;
    instr_byte_op = ~instr_byte_op;
    instr_byte_op_m1 = ~instr_byte_op_m1;
  endtask : issue
  task automatic start(input logic [1:0] kind);
    @(negedge sys_clk);
    sio_valid = 1'b1;
    sio_kind = kind;
    @(negedge sys_clk);
    sio_valid = 1'b0;
    sio_kind = ~kind;
  endtask : start
endmodule : cls_cpu_model

// ---- dv/cls_io_regs_tb.sv ----
/* Self-checking bench for cls_io_regs: loads, senses and starts through the CPU model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module cls_io_regs_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cpu_level7_active = 1'b0;
  logic cpu_level7_enabled = 1'b0;
  logic print_installed = 1'b1;
  logic instr_valid, sio_valid, load_done, sense_valid, processor_check, program_check;
  logic sio_accept, sio_abort, diag_mode, aborted_op_flag;
  logic [7:0] instr_opcode, instr_qbyte, instr_byte_op, instr_byte_op_m1;
  logic [7:0] sense_byte_op, sense_byte_op_m1, sio_length;
  logic [1:0] sio_kind;
  logic [15:0] sio_address;
  logic [5:0] sio_heads;
  int n_mismatch = 0;
  int n_tests = 0;
  always #50 sys_clk = ~sys_clk;
  cls_cpu_model cpu (.sys_clk(sys_clk), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .instr_qbyte(instr_qbyte), .instr_byte_op(instr_byte_op),
    .instr_byte_op_m1(instr_byte_op_m1), .sio_valid(sio_valid), .sio_kind(sio_kind));
  cls_io_regs uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .instr_qbyte(instr_qbyte), .instr_byte_op(instr_byte_op),
    .instr_byte_op_m1(instr_byte_op_m1), .cpu_level7_active(cpu_level7_active),
    .cpu_level7_enabled(cpu_level7_enabled), .print_installed(print_installed),
    .sio_valid(sio_valid), .sio_kind(sio_kind), .load_done(load_done),
    .sense_valid(sense_valid), .sense_byte_op(sense_byte_op),
    .sense_byte_op_m1(sense_byte_op_m1), .processor_check(processor_check),
    .program_check(program_check), .sio_accept(sio_accept), .sio_abort(sio_abort),
    .sio_length(sio_length), .sio_address(sio_address), .sio_heads(sio_heads),
    .diag_mode(diag_mode), .aborted_op_flag(aborted_op_flag));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic ld(input logic [7:0] op, input logic [2:0] fn, input logic [7:0] adr);
    cpu.issue(op, 4'hf, fn, adr);
    check("load_done", 16'(load_done), 16'h0001);
  endtask : ld
  task automatic sense(input logic [7:0] op, input logic [2:0] fn, input logic [15:0] exp);
    cpu.issue(op, 4'hf, fn, 8'h00);
    check("sense_valid", 16'(sense_valid), 16'h0001);
    check("sense_bytes", {sense_byte_op, sense_byte_op_m1}, exp);
  endtask : sense
  // Start, then answer and the values handed on when accepted
  task automatic sio(input logic [1:0] kind, input logic acc, input logic [7:0] len,
                     input logic [15:0] adr, input logic [5:0] heads);
    cpu.start(kind);
    check("sio_accept", 16'(sio_accept), 16'(acc));
    check("sio_abort", 16'(sio_abort), 16'(!acc));
    if (acc) begin
      check("sio_length", 16'(sio_length), 16'(len));
      check("sio_address", sio_address, adr);
      check("sio_heads", 16'(sio_heads), 16'(heads));
    end
  endtask : sio
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    check("reset_flag", 16'(aborted_op_flag), 16'h0000);
    cpu.mem[8'h11] = 8'h60; // Read count above max, punch count below it
    cpu.mem[8'h10] = 8'h30;
    cpu.mem[8'h21] = 8'h00;
    cpu.mem[8'h20] = 8'h05;
    cpu.mem[8'h31] = 8'h80;
    cpu.mem[8'h30] = 8'h05;
    cpu.mem[8'h41] = 8'h00;
    cpu.mem[8'h40] = 8'h06;
    cpu.mem[8'h51] = 8'h05; // Heads 1 and 3, count above print max
    cpu.mem[8'h50] = 8'h48;
    cpu.mem[8'h61] = 8'hc0; // No head bits set
    cpu.mem[8'h71] = 8'h00;
    cpu.mem[8'h70] = 8'h00;
    cpu.mem[8'h81] = 8'h01;
    cpu.mem[8'h91] = 8'h01;
    cpu.mem[8'h90] = 8'h00;
    ld(8'h31, 3'h0, 8'h11);
    ld(8'h71, 3'h2, 8'h11);
    ld(8'hb1, 3'h5, 8'h21);
    ld(8'h31, 3'h6, 8'h31);
    ld(8'h71, 3'h4, 8'h41);
    ld(8'h31, 3'h3, 8'h51);
    sio(2'h0, 1'b1, 8'h50, 16'h0500, 6'h00);
    sio(2'h1, 1'b1, 8'h30, 16'h0580, 6'h00);
    sio(2'h2, 1'b1, 8'h40, 16'h0600, 6'h05);
    ld(8'h31, 3'h3, 8'h61);
    check("flag_heads", 16'(aborted_op_flag), 16'h0001);
    sio(2'h2, 1'b1, 8'h40, 16'h0600, 6'h05);
    sense(8'h30, 3'h0, 16'h0505);
    check("flag_clear", 16'(aborted_op_flag), 16'h0000);
    sense(8'h70, 3'h5, 16'h0005);
    sense(8'h30, 3'h4, 16'h0006);
    // Raw counts come back unclamped: the clamp applies only at start time
    sense(8'h70, 3'h2, 16'h6030);
    cpu.issue(8'h31, 4'he, 3'h0, 8'h71);
    check("foreign_load", 16'(load_done), 16'h0000);
    cpu.issue(8'h32, 4'hf, 3'h0, 8'h71);
    check("other_opcode", 16'(load_done), 16'h0000);
    sio(2'h0, 1'b1, 8'h50, 16'h0500, 6'h00);
    ld(8'hb1, 3'h0, 8'h71);
    sio(2'h0, 1'b0, 8'h00, 16'h0000, 6'h00);
    check("flag_zero", 16'(aborted_op_flag), 16'h0001);
    ld(8'h31, 3'h2, 8'h71);
    sio(2'h1, 1'b0, 8'h00, 16'h0000, 6'h00);
    sio(2'h3, 1'b0, 8'h00, 16'h0000, 6'h00);
    ld(8'h31, 3'h1, 8'h81);
    check("diag_on", 16'(diag_mode), 16'h0001);
    ld(8'h31, 3'h1, 8'h71);
    check("diag_off", 16'(diag_mode), 16'h0000);
    ld(8'h31, 3'h3, 8'h91);
    sio(2'h2, 1'b0, 8'h00, 16'h0000, 6'h00);
    print_installed = 1'b0;
    sio(2'h2, 1'b1, 8'h00, 16'h0600, 6'h01);
    sense(8'hb0, 3'h0, 16'h0101);
    cpu_level7_active = 1'b1;
    ld(8'h31, 3'h7, 8'h11);
    check("proc_check", 16'({processor_check, program_check}), 16'h0002);
    cpu_level7_enabled = 1'b1;
    ld(8'h71, 3'h7, 8'h11);
    check("prog_check", 16'(program_check), 16'h0001);
    end_sim();
  end
  // Watchdog, far beyond the roughly 70 cycles the sequence needs
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule : cls_io_regs_tb
